// file: rtl/ext_pc_irq.sv
/*
 flag, enable and mask logic for one external interrupt pin and twelve
 pin-change inputs in two groups, with a classic wishbone register slave.
 assumes the core supplies its global interrupt enable and pulses one
 vector_taken bit per handler entry; pins may be asynchronous and pass through a two-flop synchroniser.
*/
`timescale 1ns/100ps
`default_nettype none
module ext_pc_irq
    import irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wb_req_t wb_req_i,
    output logic [WB_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_irq_input_i,
    input wire logic [NUM_PC-1:0] pin_change_input_i,
    input wire logic core_irq_enable_i,
    input wire logic [2:0] vector_taken_i,
    output logic ext_irq_vector_o,
    output logic pc_group_lo_vector_o,
    output logic pc_group_hi_vector_o
);

    irq_state_t state_reg;
    irq_state_t state_next;

    logic [NUM_PC:0] pin_level;
    logic [NUM_PC:0] pin_change;
    logic ext_level;
    logic ext_change;
    logic access;
    logic wr_any;
    logic [IDX_W-1:0] idx;
    logic wr_mask_lo;
    logic wr_mask_hi;
    logic wr_pc_flags;
    logic wr_pc_ctrl;
    logic wr_ext_en;
    logic wr_ext_flag;
    logic wr_sense;
    logic ext_set;
    logic lo_set;
    logic hi_set;
    logic ext_level_req;
    sense_t sense_next;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // word index from a byte address; low two bits ignored
    function automatic logic [IDX_W-1:0] reg_index(input logic [WB_ADR_W-1:0] adr);
        reg_index = adr[IDX_W+1:2];
    endfunction

    function automatic logic [7:0] read_byte(input logic [IDX_W-1:0] i, input irq_state_t s);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            IDX_PC_MASK_LO: b = s.mask_lo;
            IDX_PC_MASK_HI: b = {4'h0, s.mask_hi};
            IDX_PC_FLAGS: b = {6'h00, s.pc_flag};
            IDX_PC_CTRL: b = {6'h00, s.pc_en};
            IDX_EXT_ENABLE: b = {7'h00, s.ext_en};
            IDX_EXT_FLAGS: b = {7'h00, s.ext_flag};
            IDX_EXT_SENSE: b = {6'h00, s.sense};
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    pin_sampler #(
        .W(NUM_PC + 1)
    ) u_sampler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i({ext_irq_input_i, pin_change_input_i}),
        .level_o(pin_level),
        .change_o(pin_change)
    );

    assign ext_level = pin_level[NUM_PC];
    assign ext_change = pin_change[NUM_PC];

    // bus decode; writes land on the edge where ack is already high
    assign access = wb_req_i.cyc & wb_req_i.stb & state_reg.ack;
    assign wr_any = access & wb_req_i.we & wb_req_i.sel[0];
    assign idx = reg_index(wb_req_i.adr);
    assign wr_mask_lo = wr_any & (idx == IDX_PC_MASK_LO);
    assign wr_mask_hi = wr_any & (idx == IDX_PC_MASK_HI);
    assign wr_pc_flags = wr_any & (idx == IDX_PC_FLAGS);
    assign wr_pc_ctrl = wr_any & (idx == IDX_PC_CTRL);
    assign wr_ext_en = wr_any & (idx == IDX_EXT_ENABLE);
    assign wr_ext_flag = wr_any & (idx == IDX_EXT_FLAGS);
    assign wr_sense = wr_any & (idx == IDX_EXT_SENSE);

    // edge and change modes only; low level never sets the flag
    always_comb
    begin
        ext_set = 1'b0;
        unique case (state_reg.sense)
            SENSE_LOW: ext_set = 1'b0;
            SENSE_ANY: ext_set = ext_change;
            SENSE_FALL: ext_set = ext_change & ~ext_level;
            SENSE_RISE: ext_set = ext_change & ext_level;
        endcase
    end

    assign lo_set = |(pin_change[PC_LO_W-1:0] & state_reg.mask_lo);
    assign hi_set = |(pin_change[NUM_PC-1:PC_LO_W] & state_reg.mask_hi);
    assign sense_next = wr_sense ? sense_t'(wb_req_i.dat[1:0]) : state_reg.sense;

    always_comb
    begin
        state_next = state_reg;
        state_next.ack = wb_req_i.cyc & wb_req_i.stb & ~state_reg.ack;
        state_next.dat = state_next.ack ? {24'h000000, read_byte(idx, state_reg)} : 32'h00000000;
        if (wr_mask_lo)
        begin
            state_next.mask_lo = wb_req_i.dat[PC_LO_W-1:0];
        end
        if (wr_mask_hi)
        begin
            state_next.mask_hi = wb_req_i.dat[PC_HI_W-1:0];
        end
        if (wr_pc_ctrl)
        begin
            state_next.pc_en = wb_req_i.dat[1:0];
        end
        if (wr_ext_en)
        begin
            state_next.ext_en = wb_req_i.dat[BIT_EXT];
        end
        state_next.sense = sense_next;
        // clear by write-one or handler entry; a new event in the same cycle wins
        state_next.pc_flag[BIT_GROUP_LO] = (state_reg.pc_flag[BIT_GROUP_LO]
            & ~(wr_pc_flags & wb_req_i.dat[BIT_GROUP_LO])
            & ~vector_taken_i[VEC_PC_LO]) | lo_set;
        state_next.pc_flag[BIT_GROUP_HI] = (state_reg.pc_flag[BIT_GROUP_HI]
            & ~(wr_pc_flags & wb_req_i.dat[BIT_GROUP_HI])
            & ~vector_taken_i[VEC_PC_HI]) | hi_set;
        state_next.ext_flag = (state_reg.ext_flag
            & ~(wr_ext_flag & wb_req_i.dat[BIT_EXT])
            & ~vector_taken_i[VEC_EXT]) | ext_set;
        // using the next sense keeps the flag zero in every low-level cycle
        if (sense_next == SENSE_LOW)
        begin
            state_next.ext_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg.mask_lo <= RST_MASK_LO;
            state_reg.mask_hi <= RST_MASK_HI;
            state_reg.pc_en <= RST_PC_CTRL;
            state_reg.pc_flag <= RST_PC_FLAGS;
            state_reg.ext_en <= RST_EXT_ENABLE;
            state_reg.ext_flag <= RST_EXT_FLAG;
            state_reg.sense <= RST_SENSE;
            state_reg.ack <= 1'b0;
            state_reg.dat <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.dat;

    // low level requests while held low, with no flag behind it
    assign ext_level_req = (state_reg.sense == SENSE_LOW) & ~ext_level;
    assign ext_irq_vector_o = core_irq_enable_i & state_reg.ext_en
        & (state_reg.ext_flag | ext_level_req);
    assign pc_group_lo_vector_o = core_irq_enable_i & state_reg.pc_en[BIT_GROUP_LO]
        & state_reg.pc_flag[BIT_GROUP_LO];
    assign pc_group_hi_vector_o = core_irq_enable_i & state_reg.pc_en[BIT_GROUP_HI]
        & state_reg.pc_flag[BIT_GROUP_HI];

    a_ext_req_gate: assert property (ext_irq_vector_o
        |-> core_irq_enable_i && state_reg.ext_en)
        else $error("external request without both enables");

    a_ext_req_flag: assert property ((state_reg.sense != SENSE_LOW) && ext_irq_vector_o
        |-> state_reg.ext_flag)
        else $error("edge-mode external request without flag");

    a_ext_level_zero: assert property ((state_reg.sense == SENSE_LOW)
        |-> !state_reg.ext_flag)
        else $error("external flag set in low-level mode");

    a_ext_rise_sets: assert property ((state_reg.sense == SENSE_RISE) && ext_change
        && ext_level && !wr_sense |=> state_reg.ext_flag)
        else $error("rising edge did not set external flag");

    a_ext_fall_quiet: assert property ((state_reg.sense == SENSE_FALL)
        && !state_reg.ext_flag && !(ext_change && !ext_level) |=> !state_reg.ext_flag)
        else $error("external flag set without falling edge");

    a_pc_lo_req: assert property (pc_group_lo_vector_o == (core_irq_enable_i
        && state_reg.pc_en[BIT_GROUP_LO] && state_reg.pc_flag[BIT_GROUP_LO]))
        else $error("group-lo request mismatch");

    a_pc_hi_req: assert property (pc_group_hi_vector_o |-> core_irq_enable_i
        && state_reg.pc_en[BIT_GROUP_HI] && state_reg.pc_flag[BIT_GROUP_HI])
        else $error("group-hi request without enables and flag");

    a_pc_lo_pin_event: assert property ($rose(pin_level[0])
        && $past(state_reg.mask_lo[0], 2) && $stable(state_reg.mask_lo)
        |-> ##[0:1] state_reg.pc_flag[BIT_GROUP_LO])
        else $error("unmasked low pin change lost");

    a_pc_hi_set: assert property (|(pin_change[NUM_PC-1:PC_LO_W] & state_reg.mask_hi)
        |=> state_reg.pc_flag[BIT_GROUP_HI])
        else $error("group-hi change did not set flag");

    a_pc_masked_quiet: assert property (!state_reg.pc_flag[BIT_GROUP_LO]
        && (state_reg.mask_lo == 8'h00) |=> !state_reg.pc_flag[BIT_GROUP_LO])
        else $error("masked pins set group-lo flag");

    a_w1c_clear: assert property (wr_pc_flags && wb_req_i.dat[BIT_GROUP_LO] && !lo_set
        |=> !state_reg.pc_flag[BIT_GROUP_LO])
        else $error("write one did not clear group-lo flag");

    a_w0_keeps: assert property (wr_pc_flags && !wb_req_i.dat[BIT_GROUP_HI]
        && state_reg.pc_flag[BIT_GROUP_HI] && !vector_taken_i[VEC_PC_HI]
        |=> state_reg.pc_flag[BIT_GROUP_HI])
        else $error("write zero changed group-hi flag");

    a_handler_clear: assert property (vector_taken_i[VEC_EXT] && !ext_set
        |=> !state_reg.ext_flag)
        else $error("handler entry did not clear external flag");

    a_ctrl_write: assert property (wr_pc_ctrl
        |=> state_reg.pc_en == $past(wb_req_i.dat[1:0]))
        else $error("control write not stored");

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_pc_hi_fires: assert property (core_irq_enable_i && state_reg.pc_en[BIT_GROUP_HI]
        && state_reg.pc_flag[BIT_GROUP_HI] |-> pc_group_hi_vector_o)
        else $error("group-hi request missing");

    a_ext_edge_fires: assert property ((state_reg.sense != SENSE_LOW) && state_reg.ext_flag
        && state_reg.ext_en && core_irq_enable_i |-> ext_irq_vector_o)
        else $error("edge-mode external request missing");

    a_ext_level_fires: assert property ((state_reg.sense == SENSE_LOW) && !ext_level
        && state_reg.ext_en && core_irq_enable_i |-> ext_irq_vector_o)
        else $error("low-level external request missing");

    a_ext_any_sets: assert property ((state_reg.sense == SENSE_ANY) && ext_change
        && !wr_sense |=> state_reg.ext_flag)
        else $error("pin change did not set external flag");

    a_ext_fall_sets: assert property ((state_reg.sense == SENSE_FALL) && ext_change
        && !ext_level && !wr_sense |=> state_reg.ext_flag)
        else $error("falling edge did not set external flag");

    a_ext_rise_quiet: assert property ((state_reg.sense == SENSE_RISE)
        && !state_reg.ext_flag && !(ext_change && ext_level) |=> !state_reg.ext_flag)
        else $error("external flag set without rising edge");

    a_ext_w1c_clear: assert property (wr_ext_flag && wb_req_i.dat[BIT_EXT] && !ext_set
        |=> !state_reg.ext_flag)
        else $error("write one did not clear external flag");

    a_ext_w0_keeps: assert property (wr_ext_flag && !wb_req_i.dat[BIT_EXT]
        && state_reg.ext_flag && !vector_taken_i[VEC_EXT] |=> state_reg.ext_flag)
        else $error("write zero changed external flag");

    a_hi_w1c_clear: assert property (wr_pc_flags && wb_req_i.dat[BIT_GROUP_HI] && !hi_set
        |=> !state_reg.pc_flag[BIT_GROUP_HI])
        else $error("write one did not clear group-hi flag");

    a_lo_w0_keeps: assert property (wr_pc_flags && !wb_req_i.dat[BIT_GROUP_LO]
        && state_reg.pc_flag[BIT_GROUP_LO] && !vector_taken_i[VEC_PC_LO]
        |=> state_reg.pc_flag[BIT_GROUP_LO])
        else $error("write zero changed group-lo flag");

    a_lo_handler_clear: assert property (vector_taken_i[VEC_PC_LO] && !lo_set
        |=> !state_reg.pc_flag[BIT_GROUP_LO])
        else $error("handler entry did not clear group-lo flag");

    a_hi_handler_clear: assert property (vector_taken_i[VEC_PC_HI] && !hi_set
        |=> !state_reg.pc_flag[BIT_GROUP_HI])
        else $error("handler entry did not clear group-hi flag");

    a_pc_lo_set: assert property (|(pin_change[PC_LO_W-1:0] & state_reg.mask_lo)
        |=> state_reg.pc_flag[BIT_GROUP_LO])
        else $error("group-lo change did not set flag");

    a_hi_masked_quiet: assert property (!state_reg.pc_flag[BIT_GROUP_HI]
        && (state_reg.mask_hi == 4'h0) |=> !state_reg.pc_flag[BIT_GROUP_HI])
        else $error("masked pins set group-hi flag");

    a_mask_lo_write: assert property (wr_mask_lo
        |=> state_reg.mask_lo == $past(wb_req_i.dat[PC_LO_W-1:0]))
        else $error("low mask write not stored");

    a_mask_hi_write: assert property (wr_mask_hi
        |=> state_reg.mask_hi == $past(wb_req_i.dat[PC_HI_W-1:0]))
        else $error("high mask write not stored");

    a_ext_en_write: assert property (wr_ext_en
        |=> state_reg.ext_en == $past(wb_req_i.dat[BIT_EXT]))
        else $error("external enable write not stored");

    a_sense_write: assert property (wr_sense
        |=> state_reg.sense == $past(wb_req_i.dat[1:0]))
        else $error("sense write not stored");

    a_sel_gates_write: assert property (access && wb_req_i.we && !wb_req_i.sel[0]
        |=> $stable(state_reg.pc_en))
        else $error("write without byte select changed control");

    a_dat_idle_zero: assert property (!wb_ack_o |-> (wb_dat_o == '0))
        else $error("read data not zero outside ack");

    a_ack_answers: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");

    a_vec_needs_enable: assert property (!core_irq_enable_i
        |-> !ext_irq_vector_o && !pc_group_lo_vector_o && !pc_group_hi_vector_o)
        else $error("vector request without global enable");

    a_hi_set_wins: assert property (wr_pc_flags && wb_req_i.dat[BIT_GROUP_HI] && hi_set
        |=> state_reg.pc_flag[BIT_GROUP_HI])
        else $error("group-hi set lost to clear");

    a_ext_set_wins: assert property (vector_taken_i[VEC_EXT] && ext_set && !wr_sense
        |=> state_reg.ext_flag)
        else $error("external set lost to handler clear");

    c_pc_lo_vector: cover property (pc_group_lo_vector_o ##1 vector_taken_i[VEC_PC_LO]);
    c_pc_hi_vector: cover property (pc_group_hi_vector_o);
    c_ext_edge_vector: cover property ((state_reg.sense == SENSE_FALL) && ext_irq_vector_o);
    c_ext_level_vector: cover property ((state_reg.sense == SENSE_LOW) && ext_irq_vector_o);
    c_set_beats_clear: cover property (wr_pc_flags && wb_req_i.dat[BIT_GROUP_LO] && lo_set);

endmodule // ext_pc_irq
`default_nettype wire

// file: rtl/irq_pkg.sv
/*
 constants, field layout, reset values and carrier types for the external
 and pin-change interrupt block.
 assumes a 32-bit classic wishbone master and a core that reports vector entry.
*/
// Function
// - external flag sets when the selected sense condition on the external pin fires
// - external vector request needs global enable, external enable and external flag, or the pin held low in low-level sense
// - each flag clears when the core enters that flag's handler
// - writing one to a flag bit clears it; writing zero leaves it
// - external flag held at zero while low-level sense is selected
// - control register at 0x12: group-hi enable bit 1, group-lo enable bit 0, reset zero
// - group-hi enabled with global enable: unmasked change on inputs 11:8 interrupts
// - group-lo enabled with global enable: unmasked change on inputs 7:0 interrupts
// - flag register 0x11 bit 1 sets on a change among inputs 11:8
// - flag register bit 0 sets on a change among inputs 7:0
// - group-hi vector requested only with global enable, group-hi enable and flag
// - group-lo vector requested only with global enable, group-lo enable and flag
// - mask register 0x0F gates inputs 7:0 one bit each, reset zero
// - mask register 0x10 bits 0 to 3 gate inputs 8 to 11, reset zero
// - sense select: 00 low level, 01 any change, 10 falling, 11 rising
// - changes are seen even when the pins are driven as outputs
package irq_pkg;

    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;
    localparam int IDX_W = 6;
    localparam int PC_LO_W = 8;
    localparam int PC_HI_W = 4;
    localparam int NUM_PC = 12;

    localparam logic [IDX_W-1:0] IDX_PC_MASK_LO = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_PC_MASK_HI = 6'h10;
    localparam logic [IDX_W-1:0] IDX_PC_FLAGS = 6'h11;
    localparam logic [IDX_W-1:0] IDX_PC_CTRL = 6'h12;
    localparam logic [IDX_W-1:0] IDX_EXT_ENABLE = 6'h13;
    localparam logic [IDX_W-1:0] IDX_EXT_FLAGS = 6'h14;
    localparam logic [IDX_W-1:0] IDX_EXT_SENSE = 6'h15;

    localparam int BIT_GROUP_LO = 0;
    localparam int BIT_GROUP_HI = 1;
    localparam int BIT_EXT = 0;
    localparam int VEC_EXT = 0;
    localparam int VEC_PC_LO = 1;
    localparam int VEC_PC_HI = 2;

    localparam logic [7:0] RST_MASK_LO = 8'h00;
    localparam logic [3:0] RST_MASK_HI = 4'h0;
    localparam logic [1:0] RST_PC_CTRL = 2'h0;
    localparam logic [1:0] RST_PC_FLAGS = 2'h0;
    localparam logic RST_EXT_ENABLE = 1'h0;
    localparam logic RST_EXT_FLAG = 1'h0;

    // sample pipeline depth before change detection is trusted
    localparam logic [1:0] SYNC_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_t;

    localparam sense_t RST_SENSE = SENSE_LOW;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [WB_DAT_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic [PC_LO_W-1:0] mask_lo;
        logic [PC_HI_W-1:0] mask_hi;
        logic [1:0] pc_en;
        logic [1:0] pc_flag;
        logic ext_en;
        logic ext_flag;
        sense_t sense;
        logic ack;
        logic [WB_DAT_W-1:0] dat;
    } irq_state_t;

endpackage

// file: rtl/pin_sampler.sv
/*
 two-flop synchroniser and change detector for a vector of pins.
 assumes pins may change at any time; no change is reported until settled.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sampler
    import irq_pkg::*;
#(
    parameter int W = 13
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pins_i,
    output logic [W-1:0] level_o,
    output logic [W-1:0] change_o
);

    typedef struct packed {
        logic [W-1:0] sync1;
        logic [W-1:0] sync2;
        logic [W-1:0] prev;
        logic [1:0] warm;
    } sampler_state_t;

    sampler_state_t state_reg;
    sampler_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.sync1 = pins_i;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        if (state_reg.warm != SYNC_SETTLE)
        begin
            state_next.warm = state_reg.warm + 2'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // pins are sampled whatever drives them, so output-driven pins count too
    assign level_o = state_reg.sync2;
    // blocked until prev holds a real sample, else reset would look like a change
    assign change_o = (state_reg.warm == SYNC_SETTLE) ?
        (state_reg.sync2 ^ state_reg.prev) : '0;

endmodule // pin_sampler
`default_nettype wire

// file: dv/core_model.sv
/*
 stand-in for the core's interrupt entry: takes one requested vector
 at a time and pulses its handler-entry bit.
 assumes vector requests are levels, one bit per vector.
*/
`timescale 1ns/100ps
`default_nettype none
module core_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic accept_i,
    input wire logic [2:0] vec_i,
    output logic [2:0] taken_o
);
    logic [1:0] wait_reg;

    always_ff @(posedge clk_i)
    begin
        taken_o <= 3'h0;
        if (rst_i)
        begin
            wait_reg <= 2'h0;
        end
        else if (wait_reg != 2'h0)
        begin
            wait_reg <= wait_reg - 2'h1;
        end
        else if (accept_i && vec_i != 3'h0)
        begin
            // lowest vector first; pause so the flag clear lands
            taken_o <= vec_i & (~vec_i + 3'h1);
            wait_reg <= 2'h3;
        end
    end
endmodule // core_model
`default_nettype wire

// file: dv/test_ext_and_pin_change_irq.sv
/*
 self-checking bench for ext_pc_irq: registers over wishbone, pin
 changes per pin, all sense modes, handler entry through core_model.
 assumes ack after one cycle and flags readable three edges after a pin change.
*/
`timescale 1ns/100ps
`default_nettype none
module test_ext_and_pin_change_irq
    import irq_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_t wb_req = '0;
    logic [WB_DAT_W-1:0] wb_dat;
    logic wb_ack;
    logic ext_pin = 1'b0;
    logic [NUM_PC-1:0] pins = '0;
    logic irq_en = 1'b0;
    logic accept = 1'b0;
    logic [2:0] taken;
    logic v_ext, v_lo, v_hi;
    logic [7:0] rd, lo, hi, f;
    logic [5:0] regs [8] = '{6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h20};
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    int q;

    always #5 clk_i = ~clk_i;

    ext_pc_irq DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack), .ext_irq_input_i(ext_pin), .pin_change_input_i(pins),
        .core_irq_enable_i(irq_en), .vector_taken_i(taken), .ext_irq_vector_o(v_ext),
        .pc_group_lo_vector_o(v_lo), .pc_group_hi_vector_o(v_hi));

    core_model core (.clk_i(clk_i), .rst_i(rst_i), .accept_i(accept),
        .vec_i({v_hi, v_lo, v_ext}), .taken_o(taken));

    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // whole run needs about 700 cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // request held until ack is seen at an edge, then dropped for a cycle
    // waits for ack however long it takes; only the cycle ceiling ends a hang
    task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d);
        wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, {24'h0, d}};
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack !== 1'b1);
        rd = wb_dat[7:0];
        chk("dat_upper", 8'(wb_dat[31:8] != 24'h000000), 8'h00);
        wb_req <= '0;
        @(posedge clk_i);
        chk("ack", {7'h0, wb_ack}, 8'h00);
    endtask

    task automatic rchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, rd, exp);
    endtask

    function automatic logic exp_ext(input logic [1:0] s, input logic rising);
        return s == 2'b01 || s == (rising ? 2'b11 : 2'b10);
    endfunction

    initial
    begin
        void'($urandom(11));
        tick(16);
        rst_i <= 1'b0;
        tick(5);
        foreach (regs[i]) rchk("reset", regs[i], 8'h00);
        lo = 8'($urandom_range(255));
        bus(1'b1, IDX_PC_MASK_LO, lo);
        rchk("mask_lo", IDX_PC_MASK_LO, lo);
        bus(1'b1, IDX_PC_MASK_HI, 8'hFF);
        rchk("mask_hi", IDX_PC_MASK_HI, 8'h0F);
        bus(1'b1, 6'h20, 8'hFF);
        rchk("unmapped", 6'h20, 8'h00);
        bus(1'b1, IDX_PC_CTRL, 8'hFF);
        rchk("ctrl", IDX_PC_CTRL, 8'h03);
        for (int p = 0; p < NUM_PC; p++)
        begin
            lo = (p < 8) ? 8'h01 << p : 8'h00;
            hi = (p >= 8) ? 8'h01 << (p - 8) : 8'h00;
            f = (p < 8) ? 8'h01 : 8'h02;
            q = (p + 1) % NUM_PC;
            irq_en <= p[0] | 1'($urandom_range(1));
            bus(1'b1, IDX_PC_MASK_LO, lo);
            bus(1'b1, IDX_PC_MASK_HI, hi);
            pins[q] <= ~pins[q];
            tick(5);
            rchk("masked", IDX_PC_FLAGS, 8'h00);
            pins[p] <= ~pins[p];
            tick(5);
            rchk("flags", IDX_PC_FLAGS, f);
            chk("vec_lo", v_lo, f[0] & irq_en);
            chk("vec_hi", v_hi, f[1] & irq_en);
            bus(1'b1, IDX_PC_CTRL, 8'h00);
            chk("vec_off", {v_hi, v_lo}, 8'h00);
            bus(1'b1, IDX_PC_CTRL, 8'h03);
            bus(1'b1, IDX_PC_FLAGS, ~f & 8'h03);
            rchk("w0_keep", IDX_PC_FLAGS, f);
            // odd pins leave through handler entry, even ones by write-one
            if (p[0])
            begin
                accept <= 1'b1;
                tick(4);
                accept <= 1'b0;
            end
            else
                bus(1'b1, IDX_PC_FLAGS, f);
            rchk("cleared", IDX_PC_FLAGS, 8'h00);
        end
        bus(1'b1, IDX_EXT_ENABLE, 8'h01);
        for (int s = 0; s < 4; s++)
        begin
            irq_en <= 1'($urandom_range(1));
            bus(1'b1, IDX_EXT_SENSE, 8'(s));
            bus(1'b1, IDX_EXT_FLAGS, 8'h01);
            ext_pin <= 1'b1;
            tick(5);
            rchk("ext_rise", IDX_EXT_FLAGS, exp_ext(2'(s), 1'b1));
            bus(1'b1, IDX_EXT_FLAGS, 8'h01);
            ext_pin <= 1'b0;
            tick(5);
            f = exp_ext(2'(s), 1'b0);
            rchk("ext_fall", IDX_EXT_FLAGS, f);
            chk("vec_ext", v_ext, (s == 0 ? 1'b1 : f[0]) & irq_en);
            accept <= 1'b1;
            tick(4);
            accept <= 1'b0;
            rchk("ext_entry", IDX_EXT_FLAGS, f & {7'h0, ~irq_en});
        end
        wrap_up();
    end
endmodule // test_ext_and_pin_change_irq
`default_nettype wire
